// file: verilog/rfc_flags_ctrl_irq.sv
// RTC flag, control and shared interrupt logic with an AHB-Lite register slave
// Function
// - Update event each second, or each minute when selected; release time per selection.
// - Writing run 1 starts countdown from preset; 0 stops it.
// - Rate field picks clock out: 32768, 1024, 1, 32768 Hz.
// - Tick field picks countdown source: 4096 Hz, 64 Hz, second, minute.
// - Update event sets tick flag; held until host writes 0.
// - Countdown event sets countdown flag; held until host writes 0.
// - Alarm match sets alarm flag; held until host writes 0.
// - External event sets event flag; held until host writes 0.
// - Data loss flag sticky, 1 after power-up, writing 1 ignored.
// - Compensation halt flag sticky, 1 after power-up, writing 1 ignored.
// - Flag bits 7:6 and control bit 1 are read-only zero.
// - Interval field picks compensation interval 0.5, 2, 10, 30 s.
// - Tick enable gates tick flag rise onto interrupt; clearing releases.
// - Update interrupt releases automatically after its return time.
// - Countdown interrupt asserts when enabled, auto-releases within 7.8 ms.
// - Alarm interrupt held low until alarm flag is cleared.
// - Interrupt pin is the OR of all enabled sources.
// - Clock reset bit clears sub-second stages, stops clock until select low.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
module rfc_flags_ctrl_irq #(
	parameter int unsigned SEC_RTN_CYC = rfc_pkg::RTN_SEC_CYC,
	parameter int unsigned MIN_RTN_CYC = rfc_pkg::RTN_MIN_CYC,
	parameter int unsigned CD_RTN_CYC  = rfc_pkg::RTN_CD_CYC
) (
	input  wire logic             clk_sys,
	input  wire logic             arst_n,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic [31:0]           hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  wire rfc_pkg::rfc_evt_t evtIn,
	input  wire rfc_pkg::rfc_osc_t oscIn,
	input  wire logic             chipSelectIn,
	output rfc_pkg::rfc_cfg_t     cfgOut,
	output logic                  clockOut,
	output logic                  irqNOut,
	output logic                  irqNOutOeN
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic regHit(input logic [31:0] addr, input logic [7:0] idx);
		regHit = (addr == {22'h0, idx, 2'b00});
	endfunction

	function automatic logic pick4(input logic [1:0] sel, input logic [3:0] src);
		pick4 = src[sel];
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Order: chip select, 32768, 1024, 1 Hz
	logic [3:0] pinRaw;
	logic [3:0] sync1_reg, sync2_reg, sync3_reg, pinF_reg;
	logic [3:0] pinF_next;

	assign pinRaw = {chipSelectIn, oscIn.clk32k, oscIn.clk1k, oscIn.clk1hz};

	// A level moves only once the last two stages agree
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pinF_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pinF_reg[i];
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 4'h8;
			sync2_reg <= 4'h8;
			sync3_reg <= 4'h8;
			pinF_reg  <= 4'h8;
		end else begin
			sync1_reg <= pinRaw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			pinF_reg  <= pinF_next;
		end
	end

	// ----------------------------------------
	// Bus address phase
	// ----------------------------------------
	logic        addrPhase;
	logic [2:0]  wrSel_reg, wrSel_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0]  ext_reg, ext_next, flags_reg, flags_next, ctrl_reg, ctrl_next;
	logic        wrExt, wrFlags, wrCtrl;

	assign addrPhase = hsel & htrans[1] & hready;
	assign wrExt     = wrSel_reg[2];
	assign wrFlags   = wrSel_reg[1];
	assign wrCtrl    = wrSel_reg[0];

	// Read data built from next values so a write just ahead is seen
	always_comb begin
		wrSel_next  = 3'b000;
		hrdata_next = hrdata_reg;
		if (addrPhase && hwrite && hsize == rfc_pkg::HSIZE_WORD) begin
			wrSel_next = {regHit(haddr, rfc_pkg::IDX_EXT), regHit(haddr, rfc_pkg::IDX_FLAGS),
				regHit(haddr, rfc_pkg::IDX_CTRL)};
		end
		if (addrPhase && !hwrite) begin
			hrdata_next = 32'h0000_0000;
			if (regHit(haddr, rfc_pkg::IDX_EXT)) begin
				hrdata_next = {24'h00_0000, ext_next};
			end
			if (regHit(haddr, rfc_pkg::IDX_FLAGS)) begin
				hrdata_next = {24'h00_0000, flags_next};
			end
			if (regHit(haddr, rfc_pkg::IDX_CTRL)) begin
				hrdata_next = {24'h00_0000, ctrl_next};
			end
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic updateEvt, tickRise, cdRise;
	logic useMin;
	logic [7:0] setVec;

	assign useMin    = ext_reg[rfc_pkg::EXT_UPDATE_SOURCE_SELECT];
	assign updateEvt = useMin ? evtIn.minTick : evtIn.secTick;
	assign tickRise  = updateEvt & ~flags_reg[rfc_pkg::FLG_TICK];
	assign cdRise    = evtIn.cdExpire & ~flags_reg[rfc_pkg::FLG_CD];
	assign setVec    = {2'b00, updateEvt, evtIn.cdExpire, evtIn.alarmMatch, evtIn.extEvent,
		evtIn.dataLoss, evtIn.compHalt};

	always_comb begin
		ext_next   = ext_reg;
		flags_next = flags_reg;
		ctrl_next  = ctrl_reg;
		if (wrExt) begin
			ext_next = hwdata[7:0] & rfc_pkg::EXT_WMASK;
		end
		// Writing 1 keeps a flag, writing 0 clears it
		if (wrFlags) begin
			flags_next = flags_reg & hwdata[7:0];
		end
		// Set after clear so an event in the clearing cycle survives
		flags_next = (flags_next | setVec) & rfc_pkg::FLAGS_WMASK;
		if (!pinF_reg[3]) begin
			ctrl_next[rfc_pkg::CTL_RST] = 1'b0;
		end
		if (wrCtrl) begin
			ctrl_next = hwdata[7:0] & rfc_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wrSel_reg  <= 3'b000;
			hrdata_reg <= 32'h0000_0000;
			ext_reg    <= rfc_pkg::EXT_RESET;
			flags_reg  <= rfc_pkg::FLAGS_RESET;
			ctrl_reg   <= rfc_pkg::CTRL_RESET;
		end else begin
			wrSel_reg  <= wrSel_next;
			hrdata_reg <= hrdata_next;
			ext_reg    <= ext_next;
			flags_reg  <= flags_next;
			ctrl_reg   <= ctrl_next;
		end
	end

	// ----------------------------------------
	// Outputs to the rest of the device
	// ----------------------------------------
	rfc_pkg::rfc_cfg_t cfg_reg, cfg_next;
	logic clockOut_reg, clockOut_next;
	logic runNow;

	assign runNow = ext_reg[rfc_pkg::EXT_RUN];

	always_comb begin
		cfg_next.updateEvent     = updateEvt;
		cfg_next.countdownRun    = runNow;
		cfg_next.countdownLoad   = wrExt & hwdata[rfc_pkg::EXT_RUN] & ~runNow;
		cfg_next.countdownTick   = runNow & pick4(ext_reg[rfc_pkg::EXT_TSEL +: 2],
			{evtIn.minTick, evtIn.secTick, evtIn.tick64, evtIn.tick4096});
		cfg_next.compIntervalSel = ctrl_reg[rfc_pkg::CTL_CSEL +: 2];
		cfg_next.clockStop       = ctrl_reg[rfc_pkg::CTL_RST];
		cfg_next.subSecClear     = wrCtrl & hwdata[rfc_pkg::CTL_RST];
		clockOut_next = pick4(ext_reg[rfc_pkg::EXT_CLOCK_OUT +: 2],
			{pinF_reg[2], pinF_reg[0], pinF_reg[1], pinF_reg[2]});
	end

	// ----------------------------------------
	// Shared interrupt
	// ----------------------------------------
	logic tickEn, cdEn, almEn, extEn;
	logic tickAct, cdAct, irqAssert;
	logic irqOeN_reg, irqOeN_next;
	logic [rfc_pkg::TIMER_W-1:0] tickLimit;

	assign tickEn    = ctrl_reg[rfc_pkg::CTL_TICKE];
	assign cdEn      = ctrl_reg[rfc_pkg::CTL_CDE];
	assign almEn     = ctrl_reg[rfc_pkg::CTL_ALME];
	assign extEn     = ctrl_reg[rfc_pkg::CTL_EXTE];
	assign tickLimit = useMin ? rfc_pkg::TIMER_W'(MIN_RTN_CYC) : rfc_pkg::TIMER_W'(SEC_RTN_CYC);

	// Timer restarts on every new rise, so two rises stretch the low level
	rfc_release_timer tickTimer (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.start   (tickRise & tickEn),
		.cancel  (~tickEn),
		.limit   (tickLimit),
		.active  (tickAct)
	);

	rfc_release_timer cdTimer (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.start   (cdRise & cdEn),
		.cancel  (~cdEn),
		.limit   (rfc_pkg::TIMER_W'(CD_RTN_CYC)),
		.active  (cdAct)
	);

	assign irqAssert = tickAct | cdAct | (almEn & flags_reg[rfc_pkg::FLG_ALM])
		| (extEn & flags_reg[rfc_pkg::FLG_EXT]);
	assign irqOeN_next = ~irqAssert;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cfg_reg      <= '0;
			clockOut_reg <= 1'b0;
			irqOeN_reg   <= 1'b1;
		end else begin
			cfg_reg      <= cfg_next;
			clockOut_reg <= clockOut_next;
			irqOeN_reg   <= irqOeN_next;
		end
	end

	assign cfgOut     = cfg_reg;
	assign clockOut   = clockOut_reg;
	assign irqNOut    = 1'b0;
	assign irqNOutOeN = irqOeN_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	logic [rfc_pkg::TIMER_W:0] cdLen_reg;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cdLen_reg <= '0;
		end else begin
			cdLen_reg <= cdAct ? cdLen_reg + 1'b1 : '0;
		end
	end

	minuteSource_a: assert property (useMin && evtIn.secTick && !evtIn.minTick
		&& !flags_reg[rfc_pkg::FLG_TICK] && !(wrFlags) |=> !flags_reg[rfc_pkg::FLG_TICK])
		else $error("second tick set tick flag in minute mode");
	// Run level follows the load pulse by one edge, since it comes from the register
	loadPulse_a: assert property (wrExt && hwdata[rfc_pkg::EXT_RUN] && !runNow
		|=> cfgOut.countdownLoad ##1 cfgOut.countdownRun)
		else $error("countdown start not seen");
	clockRate_a: assert property (ext_reg[rfc_pkg::EXT_CLOCK_OUT +: 2] == 2'b10
		|=> clockOut == $past(pinF_reg[0]))
		else $error("clock out not at 1 Hz source");
	cdTick64_a: assert property (runNow && ext_reg[rfc_pkg::EXT_TSEL +: 2] == 2'b01
		&& evtIn.tick64 |=> cfgOut.countdownTick)
		else $error("64 Hz countdown tick lost");
	tickSticky_a: assert property (updateEvt |=> flags_reg[rfc_pkg::FLG_TICK])
		else $error("update event did not set tick flag");
	alarmSetWins_a: assert property (evtIn.alarmMatch |=> flags_reg[rfc_pkg::FLG_ALM])
		else $error("alarm flag lost");
	lossHold_a: assert property (flags_reg[rfc_pkg::FLG_LOSS]
		&& !(wrFlags && !hwdata[rfc_pkg::FLG_LOSS]) |=> flags_reg[rfc_pkg::FLG_LOSS])
		else $error("data loss flag dropped without clear");
	roZero_a: assert property (flags_reg[7:6] == 2'b00 && ctrl_reg[1] == 1'b0)
		else $error("protected bit not zero");
	tickDisable_a: assert property (!tickEn |=> !tickAct)
		else $error("tick interrupt held while disabled");
	cdRelease_a: assert property (cdLen_reg <= CD_RTN_CYC)
		else $error("countdown interrupt held too long");
	cdAssert_a: assert property (cdRise && cdEn |=> ##1 !irqNOutOeN)
		else $error("countdown interrupt not driven");
	alarmHold_a: assert property (almEn && flags_reg[rfc_pkg::FLG_ALM] |=> !irqNOutOeN)
		else $error("alarm interrupt not held");
	// Control bit clears at the next edge, the stop output one edge after that
	stopRelease_a: assert property (!pinF_reg[3] && !wrCtrl |=> ##1 !cfgOut.clockStop)
		else $error("clock stop not released");

	tickIrq_c: cover property (tickRise && tickEn ##2 !irqNOutOeN);
	alarmIrq_c: cover property (evtIn.alarmMatch && almEn ##2 !irqNOutOeN);
	flagClear_c: cover property (wrFlags && flags_reg[rfc_pkg::FLG_LOSS] ##1
		!flags_reg[rfc_pkg::FLG_LOSS]);
	stopCycle_c: cover property (cfgOut.subSecClear ##[1:50] !cfgOut.clockStop);

endmodule

// file: verilog/rfc_pkg.sv
// Shared constants and carrier types for the RTC flag, control and interrupt block
package rfc_pkg;

	// ----------------------------------------
	// Register indexes (byte address is four times the index)
	// ----------------------------------------
	localparam logic [7:0] IDX_EXT   = 8'h0D;
	localparam logic [7:0] IDX_FLAGS = 8'h0E;
	localparam logic [7:0] IDX_CTRL  = 8'h0F;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int unsigned EXT_UPDATE_SOURCE_SELECT  = 5;
	localparam int unsigned EXT_RUN   = 4;
	localparam int unsigned EXT_CLOCK_OUT  = 2;
	localparam int unsigned EXT_TSEL  = 0;
	localparam int unsigned FLG_TICK  = 5;
	localparam int unsigned FLG_CD    = 4;
	localparam int unsigned FLG_ALM   = 3;
	localparam int unsigned FLG_EXT   = 2;
	localparam int unsigned FLG_LOSS  = 1;
	localparam int unsigned FLG_HALT  = 0;
	localparam int unsigned CTL_CSEL  = 6;
	localparam int unsigned CTL_TICKE = 5;
	localparam int unsigned CTL_CDE   = 4;
	localparam int unsigned CTL_ALME  = 3;
	localparam int unsigned CTL_EXTE  = 2;
	localparam int unsigned CTL_RST   = 0;

	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] EXT_RESET   = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h03;
	localparam logic [7:0] CTRL_RESET  = 8'h40;
	localparam logic [7:0] EXT_WMASK   = 8'h3F;
	localparam logic [7:0] FLAGS_WMASK = 8'h3F;
	localparam logic [7:0] CTRL_WMASK  = 8'hFD;
	localparam logic [2:0] HSIZE_WORD  = 3'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned RTN_SEC_US    = 500000;
	localparam int unsigned RTN_MIN_US    = 7813;
	localparam int unsigned RTN_CD_US     = 7800;
	localparam int unsigned RTN_SEC_CYC   = RTN_SEC_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned RTN_MIN_CYC   = RTN_MIN_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned RTN_CD_CYC    = RTN_CD_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W       = 24;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic secTick;
		logic minTick;
		logic tick4096;
		logic tick64;
		logic cdExpire;
		logic alarmMatch;
		logic extEvent;
		logic dataLoss;
		logic compHalt;
	} rfc_evt_t;

	typedef struct packed {
		logic clk32k;
		logic clk1k;
		logic clk1hz;
	} rfc_osc_t;

	typedef struct packed {
		logic       updateEvent;
		logic       countdownRun;
		logic       countdownLoad;
		logic       countdownTick;
		logic [1:0] compIntervalSel;
		logic       clockStop;
		logic       subSecClear;
	} rfc_cfg_t;

endpackage

// file: verilog/rfc_release_timer.sv
// Down counter that holds an interrupt source active for a set number of cycles
`timescale 1ns/1ps
module rfc_release_timer (
	input  wire logic                        clk_sys,
	input  wire logic                        arst_n,
	input  wire logic                        start,
	input  wire logic                        cancel,
	input  wire logic [rfc_pkg::TIMER_W-1:0] limit,
	output logic                             active
);

	logic [rfc_pkg::TIMER_W-1:0] cnt_reg;
	logic [rfc_pkg::TIMER_W-1:0] cnt_next;

	// Cancel beats start so a disabled source never asserts
	always_comb begin
		cnt_next = cnt_reg;
		if (cancel) begin
			cnt_next = '0;
		end else if (start) begin
			cnt_next = limit;
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign active = (cnt_reg != '0);

endmodule

// file: dv/rfc_host_pin.sv
// Host-side model of the shared open-drain interrupt line and its pull-up
`timescale 1ns/1ps
module rfc_host_pin (
	input  wire logic irqNOut,
	input  wire logic irqNOutOeN,
	output logic      irqPin
);
	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// The pull-up wins whenever the block lets go, so a released line never reads low
	assign irqPin = irqNOutOeN ? 1'b1 : irqNOut;
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the RTC flag, control and interrupt block
`timescale 1ns/1ps
module tb_top;
	// Short release counts keep the run brief
	localparam int          SEC_N = 20;
	localparam int          MIN_N = 10;
	localparam int          CD_N  = 12;
	localparam logic [31:0] A_EXT = 32'(rfc_pkg::IDX_EXT) << 2;
	localparam logic [31:0] A_FLG = 32'(rfc_pkg::IDX_FLAGS) << 2;
	localparam logic [31:0] A_CTL = 32'(rfc_pkg::IDX_CTRL) << 2;
	localparam logic [31:0] A_UNM = 32'h0000_0040;
	logic              clk_sys, arst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic              chipSelectIn, clockOut, irqNOut, irqNOutOeN, irqPin, clrReq;
	logic [31:0]       haddr, hwdata, hrdata;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [7:0]        seen;
	rfc_pkg::rfc_evt_t evtIn;
	rfc_pkg::rfc_osc_t oscIn;
	rfc_pkg::rfc_cfg_t cfgOut;
	int                bad_count, checks, cnt;

	assign hready = hreadyout;
	rfc_flags_ctrl_irq #(.SEC_RTN_CYC(SEC_N), .MIN_RTN_CYC(MIN_N), .CD_RTN_CYC(CD_N)) dut_u (
		.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .evtIn(evtIn), .oscIn(oscIn),
		.chipSelectIn(chipSelectIn), .cfgOut(cfgOut), .clockOut(clockOut),
		.irqNOut(irqNOut), .irqNOutOeN(irqNOutOeN));
	rfc_host_pin host_u (.irqNOut(irqNOut), .irqNOutOeN(irqNOutOeN), .irqPin(irqPin));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Config pulses last one cycle, so they are caught in a sticky copy
	always @(posedge clk_sys) seen <= clrReq ? 8'h00 : (seen | cfgOut);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chkBit(input string nm, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %b seen %b", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic busWait;
		do @(posedge clk_sys); while (hready !== 1'b1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= 1'b1;
		busWait();
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		busWait();
	endtask
	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= 1'b0;
		busWait();
		htrans <= 2'b00;
		busWait();
		chk(nm, exp, hrdata);
		chkBit("okay resp", 1'b0, hresp);
	endtask
	task automatic pulse(input int b);
		evtIn[b] <= 1'b1;
		@(posedge clk_sys);
		evtIn[b] <= 1'b0;
	endtask
	task automatic clrSeen;
		clrReq <= 1'b1;
		@(posedge clk_sys);
		clrReq <= 1'b0;
	endtask
	task automatic lowLen(output int n);
		n = 0;
		repeat (60) begin
			@(posedge clk_sys);
			#1;
			if (irqPin === 1'b0) n++;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk("flags reset", A_FLG, 32'h0000_0003);
		rchk("ctrl reset", A_CTL, 32'h0000_0040);
		rchk("ext reset", A_EXT, 32'h0000_0000);
		wr(A_FLG, 8'h03);
		rchk("ones ignored", A_FLG, 32'h0000_0003);
		wr(A_EXT, 8'h00);
		wr(A_CTL, 8'h40);
		wr(A_FLG, 8'h00);
		rchk("flags cleared", A_FLG, 32'h0000_0000);
		pulse(1);
		pulse(0);
		cyc(1);
		rchk("loss halt set", A_FLG, 32'h0000_0003);
		wr(A_FLG, 8'h00);
		wr(A_UNM, 8'hFF);
		rchk("unmapped", A_UNM, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_flags;
		int srcs[6] = '{8, 4, 3, 2, 1, 0};
		foreach (srcs[i]) begin
			pulse(srcs[i]);
			cyc(1);
		end
		wr(A_FLG, 8'hFF);
		rchk("all flags", A_FLG, 32'h0000_003F);
		chkBit("pin masked", 1'b1, irqPin);
		wr(A_FLG, 8'h00);
		rchk("flags zero", A_FLG, 32'h0000_0000);
		wr(A_EXT, 8'h20);
		pulse(8);
		cyc(1);
		rchk("sec ignored", A_FLG, 32'h0000_0000);
		pulse(7);
		cyc(1);
		rchk("minute tick", A_FLG, 32'h0000_0020);
		wr(A_FLG, 8'h00);
		wr(A_EXT, 8'h00);
		$display("test flags done");
	endtask
	task automatic t_irq;
		wr(A_CTL, 8'h60);
		pulse(8);
		lowLen(cnt);
		chkBit("sec irq len", 1'b1, cnt >= SEC_N && cnt <= SEC_N + 1);
		wr(A_FLG, 8'h00);
		wr(A_EXT, 8'h20);
		pulse(7);
		lowLen(cnt);
		chkBit("min irq len", 1'b1, cnt >= MIN_N && cnt <= MIN_N + 1);
		wr(A_FLG, 8'h00);
		wr(A_EXT, 8'h00);
		pulse(8);
		cyc(3);
		chkBit("tick irq low", 1'b0, irqPin);
		wr(A_CTL, 8'h40);
		cyc(3);
		chkBit("tick irq off", 1'b1, irqPin);
		wr(A_FLG, 8'h00);
		pulse(8);
		cyc(3);
		chkBit("tick masked", 1'b1, irqPin);
		wr(A_FLG, 8'h00);
		wr(A_CTL, 8'h50);
		pulse(4);
		lowLen(cnt);
		chkBit("cd irq len", 1'b1, cnt >= CD_N && cnt <= CD_N + 1);
		rchk("cd flag held", A_FLG, 32'h0000_0010);
		wr(A_FLG, 8'h00);
		wr(A_CTL, 8'h4C);
		pulse(3);
		pulse(2);
		lowLen(cnt);
		chkBit("alarm held", 1'b1, cnt == 60);
		wr(A_FLG, 8'h04);
		cyc(3);
		chkBit("or of sources", 1'b0, irqPin);
		wr(A_CTL, 8'h48);
		cyc(3);
		chkBit("ext gated off", 1'b1, irqPin);
		wr(A_FLG, 8'h00);
		wr(A_CTL, 8'h40);
		$display("test irq done");
	endtask
	task automatic t_cfg;
		int srcOf[4] = '{6, 5, 8, 7};
		clrSeen();
		pulse(8);
		cyc(3);
		chkBit("update event", 1'b1, seen[7]);
		wr(A_EXT, 8'h10);
		cyc(3);
		chkBit("count load", 1'b1, seen[5]);
		chkBit("count run", 1'b1, cfgOut.countdownRun);
		for (int s = 0; s < 4; s++) begin
			wr(A_EXT, 8'h10 | 8'(s));
			clrSeen();
			pulse(srcOf[(s + 1) % 4]);
			cyc(3);
			chkBit("wrong tick", 1'b0, seen[4]);
			clrSeen();
			pulse(srcOf[s]);
			cyc(3);
			chkBit("tick source", 1'b1, seen[4]);
		end
		wr(A_EXT, 8'h00);
		clrSeen();
		pulse(6);
		cyc(3);
		chkBit("stopped tick", 1'b0, seen[4]);
		chkBit("run off", 1'b0, cfgOut.countdownRun);
		for (int c = 0; c < 4; c++) begin
			wr(A_CTL, 8'(c << 6));
			cyc(2);
			chk("interval", 32'(c), 32'(cfgOut.compIntervalSel));
		end
		clrSeen();
		wr(A_CTL, 8'h43);
		cyc(3);
		chkBit("subsec clear", 1'b1, seen[0]);
		chkBit("clock stop", 1'b1, cfgOut.clockStop);
		rchk("ctrl bit1 zero", A_CTL, 32'h0000_0041);
		chipSelectIn <= 1'b0;
		cyc(8);
		chkBit("stop released", 1'b0, cfgOut.clockStop);
		rchk("reset bit off", A_CTL, 32'h0000_0040);
		chipSelectIn <= 1'b1;
		wr(A_EXT, 8'hFF);
		rchk("ext top zero", A_EXT, 32'h0000_003F);
		wr(A_EXT, 8'h00);
		wr(A_FLG, 8'h00);
		$display("test cfg done");
	endtask
	task automatic t_clkout;
		for (int s = 0; s < 4; s++) begin
			wr(A_EXT, 8'(s << 2));
			for (int p = 0; p < 8; p++) begin
				oscIn <= 3'(p);
				cyc(8);
				chkBit("clock out", s == 1 ? p[1] : (s == 2 ? p[0] : p[2]), clockOut);
			end
		end
		$display("test clkout done");
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic wrap_up;
		$display("Counts: checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		$display("FAIL watchdog expected end seen hang");
		bad_count++;
		wrap_up();
	end
	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = rfc_pkg::HSIZE_WORD;
		hwdata = 32'h0000_0000;
		evtIn = '0;
		oscIn = '0;
		chipSelectIn = 1'b1;
		clrReq = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_flags();
		t_irq();
		t_cfg();
		t_clkout();
		wrap_up();
	end
endmodule
